// >>> decoder_pkg.sv
package decoder_pkg;
	// Timing: one instruction cycle is four clock periods
	localparam int OSC_PERIODS_PER_CYCLE = 4;
	localparam int CLOCK_MHZ = 250;
	localparam int REF_OSC_MHZ = 4;
	localparam int REF_CYCLE_US = 1;
	localparam int CYCLE_NS = OSC_PERIODS_PER_CYCLE * 1000 / CLOCK_MHZ;

	typedef enum logic [3:0] {
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} phase_t;

	localparam logic [1:0] PFX_BYTE = 2'h0;
	localparam logic [1:0] PFX_BIT = 2'h1;
	localparam logic [1:0] PFX_JUMP = 2'h2;
	localparam logic [1:0] PFX_LITERAL = 2'h3;

	localparam logic [3:0] OP_STORE_MISC = 4'h0;
	localparam logic [3:0] OP_CLEAR = 4'h1;
	localparam logic [3:0] OP_SUBTRACT = 4'h2;
	localparam logic [3:0] OP_DECREMENT = 4'h3;
	localparam logic [3:0] OP_OR = 4'h4;
	localparam logic [3:0] OP_AND = 4'h5;
	localparam logic [3:0] OP_XOR = 4'h6;
	localparam logic [3:0] OP_ADD = 4'h7;
	localparam logic [3:0] OP_MOVE = 4'h8;
	localparam logic [3:0] OP_COMPLEMENT = 4'h9;
	localparam logic [3:0] OP_INCREMENT = 4'ha;
	localparam logic [3:0] OP_DECREMENT_SKIP = 4'hb;
	localparam logic [3:0] OP_ROTATE_RIGHT = 4'hc;
	localparam logic [3:0] OP_ROTATE_LEFT = 4'hd;
	localparam logic [3:0] OP_SWAP = 4'he;
	localparam logic [3:0] OP_INCREMENT_SKIP = 4'hf;

	localparam logic [3:0] LIT_OR = 4'h8;
	localparam logic [3:0] LIT_AND = 4'h9;
	localparam logic [3:0] LIT_XOR = 4'ha;
	localparam logic [3:0] LIT_UNDEFINED = 4'hb;

	localparam logic [1:0] BIT_CLEAR = 2'h0;
	localparam logic [1:0] BIT_SET = 2'h1;
	localparam logic [1:0] BIT_TEST_CLEAR = 2'h2;
	localparam logic [1:0] BIT_TEST_SET = 2'h3;

	localparam logic [6:0] MISC_RETURN = 7'h08;
	localparam logic [6:0] MISC_INT_RETURN = 7'h09;
	localparam logic [6:0] MISC_SLEEP = 7'h63;
	localparam logic [6:0] MISC_WATCHDOG = 7'h64;

	localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
	localparam logic [6:0] STATUS_ADDR = 7'h03;
	localparam logic [6:0] PORT_ADDR = 7'h06;

	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_POWER_DOWN = 3;
	localparam int ST_TO = 4;
	localparam logic [4:0] STATUS_RESET = 5'h18;

	localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
	localparam logic [31:0] STATE_OFFSET = 32'h0000_0004;
	localparam logic [31:0] PC_OFFSET = 32'h0000_0008;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_PRESCALER_T0 = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// Returns {carry, digit carry, sum}
	function automatic logic [9:0] add_flags(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [8:0] s9;
		logic [4:0] n5;
		s9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		n5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		return {s9[8], n5[4], s9[7:0]};
	endfunction : add_flags
endpackage : decoder_pkg

// >>> regfile_if.sv
`timescale 1ns/10ps
interface regfile_if;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	logic wr_en;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	modport core (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
	modport mem (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface : regfile_if

// >>> regfile_mem.sv
`timescale 1ns/10ps
module regfile_mem (
	input wire logic clock,
	input wire logic reset_n,
	regfile_if.mem rf
);
	logic [7:0] store_reg [0:127];

	always_ff @(posedge clock)
	begin
		if (rf.wr_en)
			store_reg[rf.wr_addr] <= rf.wr_data;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			rf.rd_data <= 8'h00;
		else
			rf.rd_data <= store_reg[rf.rd_addr];
	end
endmodule : regfile_mem

// >>> fourteen_bit_instruction_decoder.sv
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// Contract
// - Each instruction cycle lasts exactly four clock periods.
// - One cycle per instruction; taken skips and branches add one no-operation cycle.
// - Byte format: register address bits 6..0, bit 7 picks accumulator or register.
// - Bit format: bit index in bits 9..7, register address in bits 6..0.
// - Literal format: eight-bit immediate in low byte, opcode above.
// - Call and jump carry an 11-bit target; bit 11 chooses; two cycles.
// - Register OR, AND, XOR write the chosen destination and touch only zero.
// - Rotates go through carry, write the destination, touch only carry.
// - Decrement/increment-and-skip write destination, no flags, skip when zero.
// - Bit clear, set and two tests; tests skip when met; no flags.
// - Literal OR, AND, XOR land in the accumulator, update only zero.
// - Literal subtract is literal minus accumulator, add sums; carry, digit carry, zero.
// - Load literal leaves flags; return-with-literal loads, returns, two cycles.
// - Standby and watchdog clear take one cycle and set timeout; standby clears power-down, watchdog clear sets it.
// - Read-modify-write on the port register uses the pin levels.
// - Writing the timer-zero register clears the prescaler when assigned to it.
module fourteen_bit_instruction_decoder (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [12:0] prog_addr,
	input wire logic [13:0] prog_data,
	input wire logic [7:0] port_pins,
	output logic [7:0] port_latch,
	input wire logic [12:0] return_addr,
	output logic [12:0] push_addr,
	output logic stack_push,
	output logic stack_pop,
	input wire logic interrupt_taken,
	output logic global_interrupt_enable,
	output logic prescaler_clear,
	output logic sleep_req,
	output logic watchdog_clear
);
	regfile_if rf ();
	regfile_mem u_mem (.clock(clock), .reset_n(reset_n), .rf(rf.mem));

	decoder_pkg::phase_t phase_reg;
	decoder_pkg::phase_t phase_next;
	logic [13:0] instr_reg;
	logic nop_reg;
	logic [7:0] acc_reg;
	logic [4:0] status_reg;
	logic [12:0] pc_reg;
	logic int_enable_reg;
	logic [1:0] ctrl_reg;

	function automatic logic [9:0] byte_result(input logic [3:0] op, input logic [7:0] w,
		input logic [7:0] f, input logic cin);
		logic [9:0] r;
		r = {2'b00, w};
		case (op)
			decoder_pkg::OP_STORE_MISC: r = {2'b00, w};
			decoder_pkg::OP_CLEAR: r = 10'h000;
			decoder_pkg::OP_SUBTRACT: r = decoder_pkg::add_flags(f, ~w, 1'b1);
			decoder_pkg::OP_DECREMENT: r = {2'b00, f - 8'h01};
			decoder_pkg::OP_OR: r = {2'b00, w | f};
			decoder_pkg::OP_AND: r = {2'b00, w & f};
			decoder_pkg::OP_XOR: r = {2'b00, w ^ f};
			decoder_pkg::OP_ADD: r = decoder_pkg::add_flags(f, w, 1'b0);
			decoder_pkg::OP_MOVE: r = {2'b00, f};
			decoder_pkg::OP_COMPLEMENT: r = {2'b00, ~f};
			decoder_pkg::OP_INCREMENT: r = {2'b00, f + 8'h01};
			decoder_pkg::OP_DECREMENT_SKIP: r = {2'b00, f - 8'h01};
			decoder_pkg::OP_ROTATE_RIGHT: r = {f[0], 1'b0, cin, f[7:1]};
			decoder_pkg::OP_ROTATE_LEFT: r = {f[7], 1'b0, f[6:0], cin};
			decoder_pkg::OP_SWAP: r = {2'b00, f[3:0], f[7:4]};
			decoder_pkg::OP_INCREMENT_SKIP: r = {2'b00, f + 8'h01};
		endcase
		return r;
	endfunction : byte_result

	// The x bits of subtract/add and load/return are ignored by testing op[3:2] only
	function automatic logic [9:0] lit_result(input logic [3:0] op, input logic [7:0] w,
		input logic [7:0] k);
		logic [9:0] r;
		r = {2'b00, k};
		if (op[3:2] == 2'b11)
			r = op[1] ? decoder_pkg::add_flags(k, w, 1'b0) : decoder_pkg::add_flags(k, ~w, 1'b1);
		else if (op == decoder_pkg::LIT_OR)
			r = {2'b00, w | k};
		else if (op == decoder_pkg::LIT_AND)
			r = {2'b00, w & k};
		else if (op == decoder_pkg::LIT_XOR)
			r = {2'b00, w ^ k};
		return r;
	endfunction : lit_result

	wire [1:0] prefix = instr_reg[13:12];
	wire [3:0] op4 = instr_reg[11:8];
	wire dest = instr_reg[7];
	wire [6:0] faddr = instr_reg[6:0];
	wire [2:0] bidx = instr_reg[9:7];
	wire [7:0] k8 = instr_reg[7:0];
	wire [10:0] k11 = instr_reg[10:0];
	wire [1:0] bit_op = instr_reg[11:10];
	wire byte_grp = prefix == decoder_pkg::PFX_BYTE;
	wire bit_grp = prefix == decoder_pkg::PFX_BIT;
	wire jump_grp = prefix == decoder_pkg::PFX_JUMP;
	wire lit_grp = prefix == decoder_pkg::PFX_LITERAL;
	wire run = ctrl_reg[decoder_pkg::CTRL_RUN];

	wire commit = phase_reg == decoder_pkg::PH_Q4 && run;
	wire exec = commit && !nop_reg;
	wire misc = byte_grp && op4 == decoder_pkg::OP_STORE_MISC && !dest;
	wire is_return = misc && faddr == decoder_pkg::MISC_RETURN;
	wire is_int_return = misc && faddr == decoder_pkg::MISC_INT_RETURN;
	wire is_sleep = misc && faddr == decoder_pkg::MISC_SLEEP;
	wire is_watchdog = misc && faddr == decoder_pkg::MISC_WATCHDOG;
	wire is_lit_return = lit_grp && op4[3:2] == 2'b01;
	wire any_return = is_return || is_int_return || is_lit_return;

	// Port reads see the pins, so read-modify-write never echoes a stale latch
	wire [7:0] operand = faddr == decoder_pkg::PORT_ADDR ? port_pins :
		faddr == decoder_pkg::STATUS_ADDR ? {3'h0, status_reg} : rf.rd_data;

	wire [9:0] alu_out = byte_grp ? byte_result(op4, acc_reg, operand, status_reg[decoder_pkg::ST_C])
		: lit_result(op4, acc_reg, k8);
	wire [7:0] res = alu_out[7:0];
	wire res_zero = res == 8'h00;
	wire [7:0] bit_mask = 8'h01 << bidx;
	wire bit_value = operand[bidx];
	wire [7:0] bit_res = bit_op == decoder_pkg::BIT_SET ? operand | bit_mask : operand & ~bit_mask;
	wire bit_skip = bit_grp && ((bit_op == decoder_pkg::BIT_TEST_CLEAR && !bit_value) ||
		(bit_op == decoder_pkg::BIT_TEST_SET && bit_value));
	wire zero_skip = byte_grp && res_zero && (op4 == decoder_pkg::OP_DECREMENT_SKIP ||
		op4 == decoder_pkg::OP_INCREMENT_SKIP);
	wire skip = bit_skip || zero_skip;
	wire take_two = jump_grp || any_return || skip;

	// Destination select: bit 7 set writes the register, clear writes the accumulator
	wire wr_file = exec && ((byte_grp && dest) || (bit_grp && !bit_op[1]));
	wire wr_acc = exec && ((byte_grp && !dest && !misc) ||
		(lit_grp && op4 != decoder_pkg::LIT_UNDEFINED));
	wire [7:0] wr_data = byte_grp ? res : bit_res;
	assign rf.rd_addr = faddr;
	assign rf.wr_en = wr_file;
	assign rf.wr_addr = faddr;
	assign rf.wr_data = wr_data;

	// Flag update sets per opcode group
	wire byte_alu = byte_grp && !misc;
	wire upd_z = exec && ((byte_alu && op4 != decoder_pkg::OP_STORE_MISC &&
		op4 <= decoder_pkg::OP_INCREMENT) || (lit_grp && op4[3] &&
		op4 != decoder_pkg::LIT_UNDEFINED));
	wire upd_cdc = exec && ((byte_alu && (op4 == decoder_pkg::OP_ADD ||
		op4 == decoder_pkg::OP_SUBTRACT)) || (lit_grp && op4[3:2] == 2'b11));
	wire upd_c = upd_cdc || (exec && byte_alu && (op4 == decoder_pkg::OP_ROTATE_LEFT ||
		op4 == decoder_pkg::OP_ROTATE_RIGHT));
	wire st_write = wr_file && faddr == decoder_pkg::STATUS_ADDR;
	wire [4:0] st_base = st_write ? {status_reg[4:3], wr_data[2:0]} : status_reg;
	wire st_to = (exec && (is_sleep || is_watchdog)) ? 1'b1 : st_base[decoder_pkg::ST_TO];
	wire st_power_down = exec && is_sleep ? 1'b0 : exec && is_watchdog ? 1'b1 :
		st_base[decoder_pkg::ST_POWER_DOWN];
	wire st_z = upd_z ? res_zero : st_base[decoder_pkg::ST_Z];
	wire st_dc = upd_cdc ? alu_out[8] : st_base[decoder_pkg::ST_DC];
	wire st_c = upd_c ? alu_out[9] : st_base[decoder_pkg::ST_C];
	wire [4:0] status_next = {st_to, st_power_down, st_z, st_dc, st_c};

	wire [12:0] pc_plus1 = pc_reg + 13'h0001;
	wire [12:0] pc_plus2 = pc_reg + 13'h0002;
	wire [12:0] pc_next = any_return ? return_addr : jump_grp ? {pc_reg[12:11], k11} :
		skip ? pc_plus2 : pc_plus1;
	wire tmr_clear = wr_file && faddr == decoder_pkg::TIMER_ZERO_ADDR &&
		ctrl_reg[decoder_pkg::CTRL_PRESCALER_T0];
	wire int_enable_next = (exec && is_int_return) ? 1'b1 : interrupt_taken ? 1'b0 :
		int_enable_reg;

	// Phase ring only turns while running
	always_comb
	begin
		phase_next = phase_reg;
		unique case (phase_reg)
			decoder_pkg::PH_Q1: phase_next = run ? decoder_pkg::PH_Q2 : decoder_pkg::PH_Q1;
			decoder_pkg::PH_Q2: phase_next = run ? decoder_pkg::PH_Q3 : decoder_pkg::PH_Q2;
			decoder_pkg::PH_Q3: phase_next = run ? decoder_pkg::PH_Q4 : decoder_pkg::PH_Q3;
			decoder_pkg::PH_Q4: phase_next = run ? decoder_pkg::PH_Q1 : decoder_pkg::PH_Q4;
			default: phase_next = decoder_pkg::PH_Q1;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			phase_reg <= decoder_pkg::PH_Q1;
			instr_reg <= 14'h0000;
			nop_reg <= 1'b0;
		end
		else
		begin
			phase_reg <= phase_next;
			if (run && phase_reg == decoder_pkg::PH_Q1)
				instr_reg <= prog_data;
			if (commit)
				nop_reg <= exec && take_two;
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			acc_reg <= 8'h00;
			status_reg <= decoder_pkg::STATUS_RESET;
			pc_reg <= 13'h0000;
			int_enable_reg <= 1'b0;
			port_latch <= 8'h00;
		end
		else
		begin
			if (wr_acc)
				acc_reg <= res;
			status_reg <= status_next;
			if (exec)
				pc_reg <= pc_next;
			int_enable_reg <= int_enable_next;
			if (wr_file && faddr == decoder_pkg::PORT_ADDR)
				port_latch <= wr_data;
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			push_addr <= 13'h0000;
			stack_push <= 1'b0;
			stack_pop <= 1'b0;
			prescaler_clear <= 1'b0;
			sleep_req <= 1'b0;
			watchdog_clear <= 1'b0;
		end
		else
		begin
			push_addr <= pc_plus1;
			stack_push <= exec && jump_grp && !instr_reg[11];
			stack_pop <= exec && any_return;
			prescaler_clear <= tmr_clear;
			sleep_req <= exec && is_sleep;
			watchdog_clear <= exec && is_watchdog;
		end
	end

	assign prog_addr = pc_reg;
	assign global_interrupt_enable = int_enable_reg;

	// Bus slave: zero wait states, so reads are sampled in the address phase
	wire ahb_take = hsel && htrans[1] && hready;
	wire [31:0] read_word = haddr == decoder_pkg::CTRL_OFFSET ? {30'h0, ctrl_reg} :
		haddr == decoder_pkg::STATE_OFFSET ? {18'h0, int_enable_reg, status_reg, acc_reg} :
		haddr == decoder_pkg::PC_OFFSET ? {19'h0, pc_reg} : 32'h0000_0000;
	logic wr_pend_reg;
	logic [31:0] wr_addr_reg;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 32'h0000_0000;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ctrl_reg <= decoder_pkg::CTRL_RESET;
		end
		else
		begin
			wr_pend_reg <= ahb_take && hwrite;
			wr_addr_reg <= haddr;
			hrdata <= (ahb_take && !hwrite) ? read_word : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (wr_pend_reg && wr_addr_reg == decoder_pkg::CTRL_OFFSET)
				ctrl_reg <= hwdata[1:0];
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n || !run);

	a_cycle_four: assert property (commit |=> !commit [*3] ##1 commit)
		else $error("instruction cycle is not four clocks");
	a_single_cycle: assert property (exec && !take_two |=> !nop_reg [*4])
		else $error("plain instruction took a second cycle");
	a_second_nop: assert property (exec && take_two |=> nop_reg [*4] ##1 !nop_reg)
		else $error("second cycle not run as no-operation");
	a_acc_dest: assert property (exec && byte_grp && !dest |-> !rf.wr_en)
		else $error("accumulator destination wrote a register");
	a_file_dest: assert property (exec && byte_grp && dest |->
		rf.wr_en && rf.wr_addr == instr_reg[6:0])
		else $error("register destination not written");
	a_bit_field: assert property (exec && bit_grp && !instr_reg[11] |-> rf.wr_data ==
		(instr_reg[10] ? operand | (8'h01 << instr_reg[9:7]) : operand & ~(8'h01 << instr_reg[9:7])))
		else $error("bit index field misdecoded");
	a_load_literal: assert property (exec && lit_grp && instr_reg[11:10] == 2'b00 |=>
		acc_reg == $past(instr_reg[7:0]) && status_reg == $past(status_reg))
		else $error("load literal wrong or flags touched");
	a_jump_target: assert property (exec && jump_grp |=> pc_reg[10:0] == $past(instr_reg[10:0])
		&& stack_push == !$past(instr_reg[11]))
		else $error("call or jump target wrong");
	a_logic_zero: assert property (exec && byte_grp && instr_reg[11:8] >= 4'h4 &&
		instr_reg[11:8] <= 4'h6 |=> status_reg[2] == ($past(res) == 8'h00) &&
		status_reg[1:0] == $past(status_reg[1:0]))
		else $error("register logic flags wrong");
	a_rotate_carry: assert property (exec && byte_grp && instr_reg[11:8] == 4'hd |=>
		status_reg[0] == $past(operand[7]) && status_reg[2:1] == $past(status_reg[2:1]))
		else $error("rotate left carry wrong");
	a_skip_zero: assert property (exec && zero_skip |=> nop_reg && pc_reg == $past(pc_reg) + 13'h0002
		&& status_reg == $past(status_reg))
		else $error("skip on zero missed");
	a_bit_test: assert property (exec && bit_grp && instr_reg[11] && (operand[instr_reg[9:7]] ==
		instr_reg[10]) |=> nop_reg && pc_reg == $past(pc_reg) + 13'h0002)
		else $error("bit test skip missed");
	a_lit_logic: assert property (exec && lit_grp && instr_reg[11:8] == 4'h8 |=>
		acc_reg == ($past(acc_reg) | $past(instr_reg[7:0])) && status_reg[2] == (acc_reg == 8'h00))
		else $error("literal OR wrong");
	a_sub_literal: assert property (exec && lit_grp && instr_reg[11:9] == 3'b110 |=>
		acc_reg == $past(instr_reg[7:0]) - $past(acc_reg))
		else $error("literal subtract wrong");
	a_lit_return: assert property (exec && is_lit_return |=> stack_pop && nop_reg &&
		acc_reg == $past(instr_reg[7:0]))
		else $error("return with literal wrong");
	a_sleep_flags: assert property (exec && is_sleep |=> sleep_req && status_reg[4] && !status_reg[3]
		&& !nop_reg)
		else $error("standby flags wrong");
	a_pin_operand: assert property (instr_reg[6:0] == 7'h06 |-> operand == port_pins)
		else $error("port operand not taken from pins");
	a_prescaler: assert property (rf.wr_en && rf.wr_addr == 7'h01 && ctrl_reg[1] |=> prescaler_clear)
		else $error("prescaler not cleared");
	a_int_return: assert property (exec && is_int_return |=> int_enable_reg && stack_pop &&
		nop_reg)
		else $error("interrupt return wrong");
	a_swap_flags: assert property (exec && byte_grp && instr_reg[11:8] == 4'he |=>
		status_reg[2:0] == $past(status_reg[2:0]))
		else $error("swap changed flags");
endmodule : fourteen_bit_instruction_decoder

// >>> prog_mem_model.sv
`timescale 1ns/10ps
module prog_mem_model (
	input wire logic clock,
	input wire logic [12:0] prog_addr,
	output logic [13:0] prog_data,
	input wire logic load_en,
	input wire logic [5:0] load_addr,
	input wire logic [13:0] load_word,
	input wire logic stack_push,
	input wire logic [12:0] push_addr,
	input wire logic stack_pop,
	output logic [12:0] return_addr
);
	logic [13:0] mem [0:63];
	logic [12:0] stack [0:7];
	logic [2:0] depth;
	initial
	begin
		foreach (mem[i])
			mem[i] = 14'h0000;
		depth = 3'h0;
	end
	// Word follows the address within the cycle, ready for the edge ending Q1
	assign prog_data = mem[prog_addr[5:0]];
	always @(posedge clock)
	begin
		if (load_en)
			mem[load_addr] <= load_word;
		if (stack_push)
		begin
			stack[depth] <= push_addr;
			depth <= depth + 3'h1;
		end
		else if (stack_pop)
			depth <= depth - 3'h1;
	end
	// Empty stack shows garbage, as a real one would
	assign return_addr = stack[depth - 3'h1];
endmodule : prog_mem_model

// >>> fourteen_bit_instruction_decoder_bench.sv
`timescale 1ns/10ps
module fourteen_bit_instruction_decoder_bench;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [12:0] prog_addr;
	logic [13:0] prog_data;
	logic [7:0] port_pins = 8'ha5;
	logic [7:0] port_latch;
	logic [12:0] return_addr;
	logic [12:0] push_addr;
	logic stack_push;
	logic stack_pop;
	logic interrupt_taken = 1'b0;
	logic global_interrupt_enable;
	logic prescaler_clear;
	logic sleep_req;
	logic watchdog_clear;
	logic load_en = 1'b0;
	logic [5:0] load_addr = 6'h0;
	logic [13:0] load_word = 14'h0;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	int gap = 0;
	int max_gap = 0;
	// Pulse counts: push, pop, standby, watchdog, prescaler
	int pulses [5];
	logic [12:0] last_pc = 13'h0;
	logic [12:0] first_push;

	always #2 clock = ~clock;

	fourteen_bit_instruction_decoder dut_u (.clock, .reset_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .prog_addr,
		.prog_data, .port_pins, .port_latch, .return_addr, .push_addr, .stack_push, .stack_pop,
		.interrupt_taken, .global_interrupt_enable, .prescaler_clear, .sleep_req, .watchdog_clear);

	prog_mem_model prog_u (.clock, .prog_addr, .prog_data, .load_en, .load_addr, .load_word,
		.stack_push, .push_addr, .stack_pop, .return_addr);

	// Spacing of fetch address changes; the first change after reset has no reference
	always @(posedge clock)
	begin
		cycles++;
		gap++;
		if (prog_addr !== last_pc)
		begin
			if (last_pc !== 13'h0 && gap > max_gap)
				max_gap = gap;
			gap = 0;
			last_pc = prog_addr;
		end
		pulses[0] += int'(stack_push === 1'b1);
		pulses[1] += int'(stack_pop === 1'b1);
		pulses[2] += int'(sleep_req === 1'b1);
		pulses[3] += int'(watchdog_clear === 1'b1);
		pulses[4] += int'(prescaler_clear === 1'b1);
		if (stack_push === 1'b1 && pulses[0] == 1)
			first_push = push_addr;
		if (cycles == 20000)
		begin
			failures++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		pulses = '{default: 0};
		max_gap = 0;
		last_pc = 13'h0;
		@(posedge clock);
	endtask : do_reset

	task automatic load(input logic [13:0] prog [$]);
		foreach (prog[i])
		begin
			load_en <= 1'b1;
			load_addr <= 6'(i);
			load_word <= prog[i];
			@(posedge clock);
		end
		load_en <= 1'b0;
		@(posedge clock);
	endtask : load

	// One single transfer; called just after a rising edge
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask : wr

	task automatic rd_check(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		check(v, exp);
	endtask : rd_check

	// Poll the program counter until the program parks in its final loop
	task automatic wait_pc(input logic [31:0] exp);
		logic [31:0] v;
		int i;
		i = 0;
		do
		begin
			bus(1'b0, decoder_pkg::PC_OFFSET, 32'h0, v);
			i++;
		end
		while (v !== exp && i < 200);
		check(v, exp);
	endtask : wait_pc

	task automatic test_registers();
		rd_check(decoder_pkg::CTRL_OFFSET, 32'h0);
		rd_check(decoder_pkg::STATE_OFFSET, {19'h0, decoder_pkg::STATUS_RESET, 8'h00});
		rd_check(decoder_pkg::PC_OFFSET, 32'h0);
		rd_check(32'h0000_000c, 32'h0);
		wr(decoder_pkg::PC_OFFSET, 32'h0000_1fff);
		rd_check(decoder_pkg::PC_OFFSET, 32'h0);
		wr(decoder_pkg::CTRL_OFFSET, 32'hffff_fffc);
		rd_check(decoder_pkg::CTRL_OFFSET, 32'h0);
		$display("test registers done");
	endtask : test_registers

	task automatic test_literal();
		do_reset();
		load({14'h3310, 14'h3f15, 14'h3d25, 14'h3aff, 14'h393c, 14'h3881, 14'h2806});
		wr(decoder_pkg::CTRL_OFFSET, 32'h1);
		wait_pc(32'h6);
		rd_check(decoder_pkg::STATE_OFFSET, 32'h0000_1bbd);
		check(32'(max_gap), 32'h4);
		$display("test literal done");
	endtask : test_literal

	task automatic test_byte();
		do_reset();
		load({14'h3001, 14'h00a0, 14'h0ba0, 14'h3077, 14'h0fa0, 14'h0086, 14'h0886,
			14'h0081, 14'h17a0, 14'h1fa0, 14'h3055, 14'h0da0, 14'h06a0, 14'h280d});
		wr(decoder_pkg::CTRL_OFFSET, 32'h3);
		wait_pc(32'hd);
		// Skipped loads would leave 0x77 or 0x55 behind
		rd_check(decoder_pkg::STATE_OFFSET, 32'h0000_1901);
		check({24'h0, port_latch}, 32'h0000_00a5);
		check(32'(pulses[4]), 32'h1);
		check(32'(max_gap), 32'h8);
		$display("test byte done");
	endtask : test_byte

	task automatic test_control();
		do_reset();
		load({14'h2004, 14'h0063, 14'h0064, 14'h2803, 14'h2006, 14'h343c, 14'h0009});
		wr(decoder_pkg::CTRL_OFFSET, 32'h1);
		wait_pc(32'h3);
		rd_check(decoder_pkg::STATE_OFFSET, 32'h0000_383c);
		check(32'(pulses[0]), 32'h2);
		check({19'h0, first_push}, 32'h1);
		check(32'(pulses[1]), 32'h2);
		check(32'(pulses[2]), 32'h1);
		check(32'(pulses[3]), 32'h1);
		check(32'(max_gap), 32'h8);
		// Taking an interrupt must drop the enable again
		interrupt_taken <= 1'b1;
		@(posedge clock);
		interrupt_taken <= 1'b0;
		rd_check(decoder_pkg::STATE_OFFSET, 32'h0000_183c);
		$display("test control done");
	endtask : test_control

	initial
	begin
		do_reset();
		test_registers();
		test_literal();
		test_byte();
		test_control();
		summarize();
	end
endmodule : fourteen_bit_instruction_decoder_bench
